// *** src/cops_pkg.sv ***
// package: constants, register map and carrier types of the clock output power sequencer
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package cops_pkg;

    // ------------------------------------------------------------------------
    // timing
    // ------------------------------------------------------------------------
    localparam int CLOCK_MHZ           = 10;
    localparam int DELAY_MIN_US        = 30;
    localparam int DELAY_MAX_US        = 400;
    localparam int RELEASE_DELAY_US    = 100;
    localparam int STAGE_GAP_US        = 1;
    localparam int STARTUP_LIMIT_MS    = 3;
    // least time rounds up, longest rounds down; both are whole at 10 mhz
    localparam int DELAY_MIN_CYCLES    = DELAY_MIN_US * CLOCK_MHZ;
    localparam int DELAY_MAX_CYCLES    = DELAY_MAX_US * CLOCK_MHZ;
    localparam logic [11:0] RELEASE_DELAY_CYCLES = 12'(RELEASE_DELAY_US * CLOCK_MHZ);
    localparam logic [11:0] STAGE_GAP_CYCLES     = 12'(STAGE_GAP_US * CLOCK_MHZ);
    localparam int STARTUP_LIMIT_CYCLES = STARTUP_LIMIT_MS * 1000 * CLOCK_MHZ;

    // ------------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------------
    localparam logic [7:0] CTRL_OFFSET    = 8'h00;
    localparam logic [7:0] STATUS_OFFSET  = 8'h04;
    localparam int CTRL_STOP_MASK_LSB     = 0;
    localparam int CTRL_MULT_SEL_BIT      = 3;
    localparam int CTRL_FREE_STOP_BIT     = 4;
    localparam int STATUS_STATE_LSB       = 0;
    localparam int STATUS_LOCK_BIT        = 8;
    localparam int STATUS_PINS_LSB        = 9;
    localparam int STATUS_LATE_BIT        = 12;
    localparam logic [2:0] CTRL_STOP_MASK_RESET = 3'h7;
    localparam logic       CTRL_MULT_SEL_RESET  = 1'h0;
    localparam logic       CTRL_FREE_STOP_RESET = 1'h1;

    // ------------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_OFF   = 7'h01,
        ST_LOCK  = 7'h02,
        ST_FIRST = 7'h04,
        ST_BUF   = 7'h08,
        ST_PCI   = 7'h10,
        ST_REST  = 7'h20,
        ST_RUN   = 7'h40
    } cops_state_type;

    // one enable per output group, high lets the group run
    typedef struct packed {
        logic fixed_sixtysix;
        logic feedback_buffered;
        logic other_buffered;
        logic pci;
        logic pci_free;
        logic display_48;
        logic ref_out;
    } cops_gate_type;

    // drive control of the three differential cpu pairs
    typedef struct packed {
        logic [2:0] run;
        logic [2:0] true_hold;
        logic [2:0] comp_oe;
        logic       double_current;
        logic       mult_sel;
    } cops_proc_type;

    typedef struct packed {
        logic [2:0] stop_mask;
        logic       mult_sel;
        logic       free_stoppable;
    } cops_ctrl_type;

endpackage

// *** src/cops_sync.sv ***
// three-stage pin synchroniser whose output moves once two samples agree
`timescale 1ns/1ps
module cops_sync #(
    parameter int         WIDTH = 1,
    parameter logic [3:0] RESET = 4'h0
) (
    // clock and reset
    input  wire logic             clock,
    input  wire logic             rstn,
    // pins and filtered levels
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level
);
    import cops_pkg::*;

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sample_reg;
    logic [WIDTH-1:0] check_reg;
    logic [WIDTH-1:0] level_reg;

    // ------------------------------------------------------------------------
    // stages
    // ------------------------------------------------------------------------
    // meta_reg feeds only sample_reg; a glitch must be seen twice to count
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            meta_reg   <= RESET[WIDTH-1:0];
            sample_reg <= RESET[WIDTH-1:0];
            check_reg  <= RESET[WIDTH-1:0];
        end else begin
            meta_reg   <= pin;
            sample_reg <= meta_reg;
            check_reg  <= sample_reg;
        end
    end

    // per-bit agreement filter
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                level_reg[i] <= RESET[i];
            end else if (sample_reg[i] == check_reg[i]) begin
                level_reg[i] <= check_reg[i];
            end
        end
    end

    assign level = level_reg;

endmodule

// *** src/cops_sequencer.sv ***
// clock output power sequencer: suspend exit staging, stop pins and apb registers
//
// Design decisions made here: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module cops_sequencer #(
    parameter int unsigned STARTUP_LIMIT_CYCLES = cops_pkg::STARTUP_LIMIT_CYCLES
) (
    // clock and reset
    input  wire logic                  clock,
    input  wire logic                  rstn,
    // power management pins, active low, asynchronous
    input  wire logic                  power_down_n,
    input  wire logic                  pci_stop_n,
    input  wire logic                  cpu_stop_n,
    // pll lock detector, asynchronous
    input  wire logic                  pll_lock,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    // output gating and drive
    output cops_pkg::cops_gate_type    gate,
    output cops_pkg::cops_proc_type    proc,
    output logic                       pll_power_up
);
    import cops_pkg::*;

    // ------------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------------
    logic [3:0]     pins_s;
    logic           pd_s;
    logic           pci_stop_s;
    logic           cpu_stop_s;
    logic           lock_s;
    cops_state_type state_reg;
    cops_state_type state_next;
    logic [11:0]    timer_reg;
    logic [11:0]    timer_next;
    logic [15:0]    startup_reg;
    logic           late_reg;
    logic           late_next;
    cops_ctrl_type  ctrl_reg;
    cops_gate_type  gate_reg;
    cops_gate_type  gate_next;
    cops_proc_type  proc_reg;
    cops_proc_type  proc_next;
    logic           ref_stage_reg;
    logic           pll_reg;
    logic [31:0]    prdata_reg;
    logic           pready_reg;
    logic           pslverr_reg;
    logic [11:0]    first_age_reg;
    logic           setup_take;
    logic           write_take;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    // power_down_n resets low so the block starts powered down and locks first
    cops_sync #(
        .WIDTH (4),
        .RESET (4'hc)
    ) u_sync (
        .clock (clock),
        .rstn  (rstn),
        .pin   ({pci_stop_n, cpu_stop_n, pll_lock, power_down_n}),
        .level (pins_s)
    );

    // filtered levels: a change counts after two agreeing samples
    assign pd_s       = pins_s[0];
    assign lock_s     = pins_s[1];
    assign cpu_stop_s = pins_s[2];
    assign pci_stop_s = pins_s[3];

    // ------------------------------------------------------------------------
    // sequencing state machine
    // ------------------------------------------------------------------------
    wire timer_gap  = (timer_reg == STAGE_GAP_CYCLES - 12'h001);
    wire timer_hold = (timer_reg == RELEASE_DELAY_CYCLES - 12'h001);

    // power-down wins from any state, independent of the cpu frequency
    always_comb begin
        state_next = state_reg;
        if (!pd_s) begin
            state_next = ST_OFF;
        end else begin
            case (state_reg)
                ST_OFF:   state_next = ST_LOCK;
                ST_LOCK:  if (lock_s) state_next = ST_FIRST;
                ST_FIRST: if (timer_hold) state_next = ST_BUF;
                ST_BUF:   if (timer_gap) state_next = ST_PCI;
                ST_PCI:   if (timer_gap) state_next = ST_REST;
                ST_REST:  if (timer_gap) state_next = ST_RUN;
                ST_RUN:   state_next = ST_RUN;
                default:  state_next = ST_OFF;
            endcase
        end
    end

    // delay counter runs on the fixed reference, not a selectable output clock
    assign timer_next = (state_next != state_reg) ? 12'h000 :
                        (timer_reg == 12'hfff) ? timer_reg : timer_reg + 12'h001;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_OFF;
            timer_reg <= 12'h000;
        end else begin
            state_reg <= state_next;
            timer_reg <= timer_next;
        end
    end

    // ------------------------------------------------------------------------
    // startup watchdog
    // ------------------------------------------------------------------------
    wire starting  = (state_reg != ST_OFF) && (state_reg != ST_RUN);
    wire late_hit  = starting && (startup_reg == 16'(STARTUP_LIMIT_CYCLES));
    wire late_clr  = write_take && (paddr == STATUS_OFFSET) && pwdata[STATUS_LATE_BIT];
    // a late start is sticky; a set in the clearing cycle wins
    assign late_next = late_hit | (late_reg & ~late_clr);

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            startup_reg <= 16'h0000;
            late_reg    <= 1'b0;
        end else begin
            startup_reg <= !starting ? 16'h0000 :
                           late_hit ? startup_reg : startup_reg + 16'h0001;
            late_reg    <= late_next;
        end
    end

    // ------------------------------------------------------------------------
    // output gating
    // ------------------------------------------------------------------------
    wire rel_rest  = (state_next == ST_REST) || (state_next == ST_RUN);
    wire rel_pci   = (state_next == ST_PCI) || rel_rest;
    wire rel_buf   = (state_next == ST_BUF) || rel_pci;
    wire rel_first = (state_next == ST_FIRST) || rel_buf;
    wire [2:0] cpu_halt = cpu_stop_s ? 3'h0 : ctrl_reg.stop_mask;

    // staged group enables; nothing beyond lock-gated group before the delay
    assign gate_next.fixed_sixtysix    = rel_first;
    assign gate_next.feedback_buffered = rel_first;
    assign gate_next.other_buffered    = rel_buf;
    assign gate_next.pci               = rel_pci & pci_stop_s;
    assign gate_next.pci_free          = rel_pci &
                                         (pci_stop_s | ~ctrl_reg.free_stoppable);
    assign gate_next.display_48        = rel_rest;
    // reference waits one extra cycle on the way up, stops with the rest
    assign gate_next.ref_out           = rel_rest & ref_stage_reg;

    // cpu pairs: stopped pairs rest true-high, complement floating
    assign proc_next.run            = rel_first ? ~cpu_halt : 3'h0;
    assign proc_next.true_hold      = ~proc_next.run;
    assign proc_next.comp_oe        = proc_next.run;
    // powered down or waiting for lock: bias at twice the reference current
    assign proc_next.double_current = ~rel_first;
    assign proc_next.mult_sel       = ctrl_reg.mult_sel;

    // enables are registered; the output cells take them only in clock low phase
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            gate_reg      <= '0;
            proc_reg      <= '{run: 3'h0, true_hold: 3'h7, comp_oe: 3'h0,
                               double_current: 1'b1, mult_sel: CTRL_MULT_SEL_RESET};
            ref_stage_reg <= 1'b0;
            pll_reg       <= 1'b0;
        end else begin
            gate_reg      <= gate_next;
            proc_reg      <= proc_next;
            ref_stage_reg <= rel_rest;
            pll_reg       <= (state_next != ST_OFF);
        end
    end

    assign gate         = gate_reg;
    assign proc         = proc_reg;
    assign pll_power_up = pll_reg;

    // ------------------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------------------
    function automatic logic reg_hit(input logic [7:0] addr);
        reg_hit = (addr == CTRL_OFFSET) || (addr == STATUS_OFFSET);
    endfunction

    // one wait-free access cycle: pready rises in the first access cycle
    assign setup_take = psel && !penable;
    assign write_take = psel && penable && pready_reg && pwrite && reg_hit(paddr);
    wire [31:0] ctrl_word   = {27'h0, ctrl_reg.free_stoppable, ctrl_reg.mult_sel,
                               ctrl_reg.stop_mask};
    wire [31:0] status_word = {19'h0, late_reg, pci_stop_s, cpu_stop_s, pd_s,
                               lock_s, 1'b0, state_reg};
    wire [31:0] read_word   = (paddr == CTRL_OFFSET)   ? ctrl_word :
                              (paddr == STATUS_OFFSET) ? status_word : 32'h0;

    // answer register, loaded in the setup cycle
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= setup_take;
            pslverr_reg <= setup_take && !reg_hit(paddr);
            prdata_reg  <= (setup_take && !pwrite) ? read_word : 32'h0;
        end
    end

    // control register; writes take effect at the access edge
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg <= '{stop_mask: CTRL_STOP_MASK_RESET, mult_sel: CTRL_MULT_SEL_RESET,
                          free_stoppable: CTRL_FREE_STOP_RESET};
        end else if (write_take && paddr == CTRL_OFFSET) begin
            ctrl_reg <= '{stop_mask: pwdata[CTRL_STOP_MASK_LSB +: 3],
                          mult_sel: pwdata[CTRL_MULT_SEL_BIT],
                          free_stoppable: pwdata[CTRL_FREE_STOP_BIT]};
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    // cycles spent between the first release and the buffered release
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            first_age_reg <= 12'h000;
        end else if (state_reg == ST_LOCK) begin
            first_age_reg <= 12'h000;
        end else if (state_reg == ST_FIRST) begin
            first_age_reg <= first_age_reg + 12'h001;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    a_lock_holds_all: assert property (
        state_reg == ST_LOCK |-> gate_reg == '0 && proc_reg.run == 3'h0)
        else $error("outputs released before lock");
    a_first_group: assert property (
        $rose(gate_reg.feedback_buffered) |-> gate_reg.fixed_sixtysix &&
        (proc_reg.run == 3'h7 || !$past(cpu_stop_s)))
        else $error("first release group incomplete");
    a_first_excl: assert property (
        state_reg == ST_FIRST |-> !gate_reg.other_buffered && !gate_reg.pci &&
        !gate_reg.pci_free && !gate_reg.display_48 && !gate_reg.ref_out)
        else $error("late group released too early");
    a_delay_window: assert property (
        $rose(gate_reg.other_buffered) |-> first_age_reg > DELAY_MIN_CYCLES &&
        first_age_reg < DELAY_MAX_CYCLES)
        else $error("release delay outside window");
    a_buf_then_pci: assert property (
        $rose(gate_reg.other_buffered) |-> !gate_reg.pci ##[1:20] gate_reg.pci || !pd_s ||
        !pci_stop_s)
        else $error("pci not released after buffered outputs");
    a_rest_after_buf: assert property (
        gate_reg.display_48 |-> gate_reg.other_buffered ##1 gate_reg.ref_out || !pd_s)
        else $error("48 mhz or reference out of order");
    a_pci_stop_low: assert property (
        !pci_stop_s |=> !gate_reg.pci)
        else $error("pci outputs not stopped");
    a_cpu_stop_mask: assert property (
        !cpu_stop_s |=> (proc_reg.run & ctrl_reg.stop_mask) == 3'h0 ||
        $changed(ctrl_reg))
        else $error("stoppable cpu pair still running");
    a_stop_bias: assert property (
        state_reg == ST_RUN && !proc_reg.run[0] |-> proc_reg.true_hold[0] &&
        !proc_reg.comp_oe[0] && !proc_reg.double_current)
        else $error("stopped cpu pair drive wrong");
    a_pd_gates_off: assert property (
        !pd_s ##1 !pd_s |-> gate_reg == '0)
        else $error("non-cpu output running in power-down");
    a_pd_cpu_bias: assert property (
        state_reg == ST_OFF |-> proc_reg.double_current && proc_reg.true_hold == 3'h7 &&
        proc_reg.comp_oe == 3'h0)
        else $error("cpu drive wrong in power-down");

    c_reach_run: cover property (state_reg == ST_REST ##1 state_reg == ST_RUN);
    c_pci_stop: cover property (state_reg == ST_RUN && $fell(pci_stop_s));
    c_cpu_stop: cover property (state_reg == ST_RUN && $fell(cpu_stop_s));
    c_pd_entry: cover property (state_reg == ST_RUN ##1 state_reg == ST_OFF);

endmodule

// *** dv/cops_pm_model.sv ***
// far-side model: power management pin driver and pll lock detector
`timescale 1ns/1ps
module cops_pm_model (
    // clock and pll power from the sequencer
    input  wire logic clock,
    input  wire logic pll_power_up,
    // pins and lock towards the sequencer
    output logic      power_down_n,
    output logic      pci_stop_n,
    output logic      cpu_stop_n,
    output logic      pll_lock
);
    int lock_wait = 50;
    int lock_cnt  = 0;
    // ------------------------------------------------------------------------
    // pin driver
    // ------------------------------------------------------------------------
    // pins move just after a rising edge, a full period ahead of the next sample
    task automatic drive(input logic pd, input logic pci, input logic cpu);
        @(posedge clock);
        power_down_n <= pd;
        pci_stop_n   <= pci;
        cpu_stop_n   <= cpu;
    endtask
    // block powers up in suspend, stop pins idle high
    initial begin
        power_down_n = 1'b0;
        pci_stop_n   = 1'b1;
        cpu_stop_n   = 1'b1;
        pll_lock     = 1'b0;
    end
    // ------------------------------------------------------------------------
    // lock detector
    // ------------------------------------------------------------------------
    // lock after lock_wait powered cycles; lost at once when powered off
    always @(posedge clock) begin
        if (pll_power_up !== 1'b1) begin
            lock_cnt <= 0;
            pll_lock <= 1'b0;
        end else if (lock_cnt < lock_wait) begin
            lock_cnt <= lock_cnt + 1;
        end else begin
            pll_lock <= 1'b1;
        end
    end
endmodule

// *** dv/clock_output_power_sequencer_tb_top.sv ***
// testbench: suspend exit staging, stop pins and registers of the sequencer
`timescale 1ns/1ps
module clock_output_power_sequencer_tb_top;
    import cops_pkg::*;
    logic          clock = 1'b0;
    logic          rstn = 1'b0;
    logic          psel = 1'b0;
    logic          penable = 1'b0;
    logic          pwrite = 1'b0;
    logic [7:0]    paddr = 8'h00;
    logic [31:0]   pwdata = 32'h0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    logic          pll_power_up;
    logic          power_down_n;
    logic          pci_stop_n;
    logic          cpu_stop_n;
    logic          pll_lock;
    cops_gate_type gate;
    cops_proc_type proc;
    logic [31:0]   rd;
    logic          er;
    int            err_total = 0;
    int            samples_checked = 0;
    int            cycles = 0;
    // ------------------------------------------------------------------------
    // instances
    // ------------------------------------------------------------------------
    // short startup limit keeps the late-start case cheap to reach
    cops_sequencer #(.STARTUP_LIMIT_CYCLES(2000)) uut (
        .clock(clock), .rstn(rstn), .power_down_n(power_down_n), .pci_stop_n(pci_stop_n),
        .cpu_stop_n(cpu_stop_n), .pll_lock(pll_lock), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gate(gate), .proc(proc), .pll_power_up(pll_power_up));
    cops_pm_model pm (.clock(clock), .pll_power_up(pll_power_up), .power_down_n(power_down_n),
        .pci_stop_n(pci_stop_n), .cpu_stop_n(cpu_stop_n), .pll_lock(pll_lock));
    // ------------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------------
    initial forever #50 clock = ~clock;
    // hang guard; a full run needs well under half of this
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(negedge clock);
    endtask
    // one apb transfer; request held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // ------------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------------
    task automatic t_reset();
        chk(32'(gate), 32'h0);
        chk(32'(proc), 32'h0e2);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd, 32'h17);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'hc01);
        apb(1'b1, 8'h08, 32'hffff);
        chk({rd[30:0], er}, 32'h1);
        $display("done: reset");
    endtask
    // a one-cycle high pulse on power_down_n must not start an exit
    task automatic t_glitch();
        pm.drive(1'b1, 1'b1, 1'b1);
        pm.drive(1'b0, 1'b1, 1'b1);
        tk(12);
        chk(pll_power_up, 1'b0);
        $display("done: glitch");
    endtask
    task automatic t_exit(input int lw, input logic late);
        int n;
        time t0;
        time t1;
        pm.lock_wait = lw;
        t0 = $time;
        pm.drive(1'b1, 1'b1, 1'b1);
        for (n = 0; n < 9000 && gate === 7'h00; n++) tk(1);
        chk(pll_lock, 1'b1);
        chk(32'(gate), 32'h60);
        chk(32'(proc.run), 32'h7);
        t1 = $time;
        for (n = 0; n < 5000 && gate.other_buffered !== 1'b1; n++) tk(1);
        n = ($time - t1) / 100;
        chk(n > DELAY_MIN_CYCLES && n < DELAY_MAX_CYCLES, 1'b1);
        chk(32'(gate), 32'h70);
        for (n = 0; n < 100 && gate.pci !== 1'b1; n++) tk(1);
        chk(32'(gate), 32'h7c);
        for (n = 0; n < 100 && gate.ref_out !== 1'b1; n++) tk(1);
        chk(32'(gate), 32'h7f);
        chk(($time - t0) / 100 < STARTUP_LIMIT_CYCLES, 1'b1);
        chk(pll_power_up, 1'b1);
        tk(20);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, {19'h0, late, 12'hf40});
        apb(1'b1, STATUS_OFFSET, 32'h1000);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd, 32'hf40);
        $display("done: exit");
    endtask
    task automatic t_pci();
        pm.drive(1'b1, 1'b0, 1'b1);
        tk(7);
        chk(32'(gate), 32'h73);
        pm.drive(1'b1, 1'b1, 1'b1);
        tk(7);
        chk(32'(gate), 32'h7f);
        apb(1'b1, CTRL_OFFSET, 32'h0d);
        apb(1'b0, CTRL_OFFSET, 32'h0);
        chk(rd, 32'h0d);
        pm.drive(1'b1, 1'b0, 1'b1);
        tk(7);
        chk(32'(gate), 32'h77);
        pm.drive(1'b1, 1'b1, 1'b1);
        tk(7);
        $display("done: pci stop");
    endtask
    // mask 5 from t_pci: pairs 0 and 2 stop, pair 1 keeps running
    task automatic t_cpu();
        pm.drive(1'b1, 1'b1, 1'b0);
        tk(7);
        chk(32'(proc.run), 32'h2);
        chk(32'(proc.true_hold & 3'h5), 32'h5);
        chk(32'(proc.comp_oe & 3'h5), 32'h0);
        chk({proc.mult_sel, proc.double_current}, 2'b10);
        chk(32'(gate), 32'h7f);
        pm.drive(1'b1, 1'b1, 1'b1);
        tk(7);
        chk(32'(proc.run), 32'h7);
        $display("done: cpu stop");
    endtask
    task automatic t_pd();
        pm.drive(1'b0, 1'b1, 1'b1);
        tk(8);
        chk(32'(gate), 32'h0);
        chk({proc.run, proc.true_hold, proc.comp_oe, proc.double_current}, 10'h071);
        apb(1'b0, STATUS_OFFSET, 32'h0);
        chk(rd & 32'h7f, 32'h01);
        $display("done: power down");
    endtask
    // ------------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        tk(2);
        t_reset();
        t_glitch();
        t_exit(2500, 1'b1);
        t_pci();
        t_cpu();
        t_pd();
        t_exit(50, 1'b0);
        conclude();
    end
endmodule
